// ### core/ppm_pkg.sv
// shared constants for the pin pulse measure and output block
package ppm_pkg;
    // clock and tick timing
    localparam int CLK_MHZ = 25;
    localparam int TICK_US = 2;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    // start-edge wait limit, in microseconds and in ticks
    localparam int WAIT_LIMIT_US = 131000;
    localparam logic [15:0] WAIT_LIMIT_TICKS = 16'(WAIT_LIMIT_US / TICK_US);
    // settle cycles after a new pin selection before edges are believed
    localparam logic [15:0] ARM_CYCLES = 16'h0002;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_LEN = 12'h004;
    localparam logic [11:0] ADDR_DIR = 12'h008;
    localparam logic [11:0] ADDR_OUT = 12'h00C;
    localparam logic [11:0] ADDR_IN = 12'h010;
    localparam logic [11:0] ADDR_RESULT = 12'h014;

    // control register fields
    localparam int CTRL_MEAS_BIT = 0;
    localparam int CTRL_PULSE_BIT = 1;
    localparam int CTRL_PIN_LSB = 4;
    localparam int CTRL_POL_BIT = 8;
    localparam int CTRL_BYTE_BIT = 9;
    // result register fields
    localparam int RES_BUSY_BIT = 16;

    // reset values
    localparam logic [15:0] DIR_RST = 16'h0000;
    localparam logic [15:0] OUT_RST = 16'h0000;
    localparam logic [15:0] LEN_RST = 16'h0000;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // one-hot sequencer states
    typedef enum logic [5:0] {
        PPM_IDLE = 6'h01,
        PPM_M_ARM = 6'h02,
        PPM_M_WAIT = 6'h04,
        PPM_M_COUNT = 6'h08,
        PPM_P_DRIVE = 6'h10,
        PPM_P_HOLD = 6'h20
    } ppm_state_t;
endpackage

// ### core/ppm_tick.sv
// two microsecond tick divider with synchronous restart
`timescale 1ns/1ps
module ppm_tick #(
    parameter int CYCLES = ppm_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } ppm_tick_st_t;

    ppm_tick_st_t r;
    ppm_tick_st_t next_r;

    // restart aligns the first tick a full period after clear
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (clear) begin
            next_r.cnt = 16'h0000;
        end else if (r.cnt == 16'(CYCLES - 1)) begin
            next_r.cnt = 16'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule

// ### core/ppm_edge.sv
// samples the selected pin and keeps its previous level for edge detection
`timescale 1ns/1ps
module ppm_edge #(
    parameter int PINS = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [3:0] sel,
    output logic level,
    output logic prev
);
    typedef struct packed {
        logic level;
        logic prev;
    } ppm_edge_st_t;

    ppm_edge_st_t r;
    ppm_edge_st_t next_r;

    // two-stage history of the chosen pin
    always_comb begin
        next_r.level = pin_in[sel];
        next_r.prev = r.level;
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.level;
    assign prev = r.prev;
endmodule

// ### core/ppm_top.sv
// pin pulse measure and pulse output unit with pin direction and latch bits
// What this block does
// - measured pulse width is reported in 2 microsecond ticks
// - measuring forces the selected pin to input and leaves it input
// - polarity 1 times a high pulse, 0 times a low pulse
// - counter starts on entry into selected level, stops at next change
// - a pin already at the level does not start the counter
// - no start edge within 0.131 s gives a zero result
// - a pulse longer than the counter range gives a zero result
// - valid widths are 1..65535, or 1..255 for byte destination
// - counter is always 16 bits; byte destination keeps low 8 bits
// - pulse output holds for a 16-bit count of 2 microsecond ticks
// - pulse output makes the pin an output on the edge of the first inversion and leaves it so
// - pulse inverts the latch, waits, then inverts it back
// - direction bit 1 connects the driver and makes the pin output
// - after reset all sixteen pins are inputs
// - pin-driving operations switch the pin to output and leave it
// - writing the latch of an output pin changes the driven level at once
// - input-to-output change drives the held latch; latch writable as input
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ppm_top #(
    parameter int PINS = 16,
    parameter logic [15:0] WAIT_LIMIT = ppm_pkg::WAIT_LIMIT_TICKS,
    parameter int TICK_CYCLES = ppm_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe
);
    typedef struct packed {
        ppm_pkg::ppm_state_t state;
        logic [PINS-1:0] dir;
        logic [PINS-1:0] outl;
        logic [PINS-1:0] in_level;
        logic [3:0] pin_sel;
        logic pol;
        logic dest8;
        logic [15:0] len;
        logic [15:0] cnt;
        logic [15:0] wait_cnt;
        logic [15:0] result;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ppm_st_t;

    ppm_st_t r;
    ppm_st_t next_r;
    logic tick;
    logic tick_clr;
    logic sel_level;
    logic sel_prev;

    // register map, one aligned 32-bit word each; offsets live in the package
    //   control: measure start, pulse start, pin number, polarity, byte destination
    //   length: pulse length in ticks
    //   direction: one bit a pin, a 1 turns the pin driver on
    //   output latch: one bit a pin, the level driven while the driver is on
    //   input: sampled pin levels, read only
    //   result: last width and the busy flag, read only
    // start bits read back as zero; measure wins when both are set
    // unmapped offsets answer with an error, reads of them return zero
    // writes to read-only words are accepted on the bus and have no effect

    // one-hot mask of a pin; the pin helpers below build on it
    function automatic logic [PINS-1:0] bit_mask(input logic [3:0] idx);
        logic [PINS-1:0] m;
        m = '0;
        m[idx] = 1'b1;
        return m;
    endfunction

    // turns one pin on in a per-pin word
    function automatic logic [PINS-1:0] set_pin(
        input logic [PINS-1:0] v,
        input logic [3:0] idx
    );
        return v | bit_mask(idx);
    endfunction

    // turns one pin off in a per-pin word
    function automatic logic [PINS-1:0] clear_pin(
        input logic [PINS-1:0] v,
        input logic [3:0] idx
    );
        return v & ~bit_mask(idx);
    endfunction

    // inverts one pin in a per-pin word
    function automatic logic [PINS-1:0] flip_pin(
        input logic [PINS-1:0] v,
        input logic [3:0] idx
    );
        return v ^ bit_mask(idx);
    endfunction

    // one step of a 16-bit count
    function automatic logic [15:0] step16(input logic [15:0] v);
        return v + 16'h0001;
    endfunction

    // known register addresses; anything else answers with an error
    function automatic logic addr_ok(input logic [11:0] a);
        return (a == ppm_pkg::ADDR_CTRL) || (a == ppm_pkg::ADDR_LEN) ||
            (a == ppm_pkg::ADDR_DIR) || (a == ppm_pkg::ADDR_OUT) ||
            (a == ppm_pkg::ADDR_IN) || (a == ppm_pkg::ADDR_RESULT);
    endfunction

    // width as it lands in the destination
    function automatic logic [15:0] store_width(input logic [15:0] w, input logic byte_dst);
        if (byte_dst) begin
            return {8'h00, w[7:0]};
        end
        return w;
    endfunction

    // tick base, restarted whenever a timed phase begins
    ppm_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .reset(reset),
        .clear(tick_clr),
        .tick(tick)
    );

    // level history of the selected pin
    ppm_edge #(
        .PINS(PINS)
    ) u_edge (
        .clk(clk),
        .reset(reset),
        .pin_in(pin_in),
        .sel(r.pin_sel),
        .level(sel_level),
        .prev(sel_prev)
    );

    // bus slave, register writes and the two timing sequencers
    always_comb begin
        logic wr;
        logic busy;
        logic start_edge;
        logic [31:0] rd;
        logic pulse_end;
        next_r = r;
        wr = 1'b0;
        busy = 1'b0;
        start_edge = 1'b0;
        rd = 32'h0000_0000;
        pulse_end = 1'b0;
        tick_clr = 1'b0;
        next_r.pready = 1'b0;
        // pin levels sampled in any direction
        // one flop of delay: software sees the level of the cycle before
        next_r.in_level = pin_in;
        busy = (r.state != ppm_pkg::PPM_IDLE);

        // read mux; reserved bits read as zero
        case (paddr)
            ppm_pkg::ADDR_CTRL: begin
                rd[ppm_pkg::CTRL_PIN_LSB +: 4] = r.pin_sel;
                rd[ppm_pkg::CTRL_POL_BIT] = r.pol;
                rd[ppm_pkg::CTRL_BYTE_BIT] = r.dest8;
            end
            ppm_pkg::ADDR_LEN: begin
                rd[15:0] = r.len;
            end
            ppm_pkg::ADDR_DIR: begin
                rd[PINS-1:0] = r.dir;
            end
            ppm_pkg::ADDR_OUT: begin
                rd[PINS-1:0] = r.outl;
            end
            ppm_pkg::ADDR_IN: begin
                rd[PINS-1:0] = r.in_level;
            end
            ppm_pkg::ADDR_RESULT: begin
                rd[15:0] = r.result;
                rd[ppm_pkg::RES_BUSY_BIT] = busy;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase

        // one wait state: answer is registered so outputs come from flops
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.pslverr = !addr_ok(paddr);
            next_r.prdata = rd;
        end
        // the write lands on the second access edge, where pready is seen high
        wr = psel && penable && r.pready && pwrite && addr_ok(paddr);

        // software writes; the sequencer below overrides the same bits
        if (wr) begin
            case (paddr)
                ppm_pkg::ADDR_LEN: begin
                    next_r.len = pwdata[15:0];
                end
                ppm_pkg::ADDR_DIR: begin
                    next_r.dir = pwdata[PINS-1:0];
                end
                ppm_pkg::ADDR_OUT: begin
                    // latch drives the pin directly when output
                    next_r.outl = pwdata[PINS-1:0];
                end
                ppm_pkg::ADDR_CTRL: begin
                    // commands and settings are ignored while busy
                    // software polls the busy flag before a new command
                    if (!busy) begin
                        next_r.pin_sel = pwdata[ppm_pkg::CTRL_PIN_LSB +: 4];
                        next_r.pol = pwdata[ppm_pkg::CTRL_POL_BIT];
                        next_r.dest8 = pwdata[ppm_pkg::CTRL_BYTE_BIT];
                        next_r.cnt = 16'h0000;
                        if (pwdata[ppm_pkg::CTRL_MEAS_BIT]) begin
                            next_r.state = ppm_pkg::PPM_M_ARM;
                        end else if (pwdata[ppm_pkg::CTRL_PULSE_BIT]) begin
                            next_r.state = ppm_pkg::PPM_P_DRIVE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // edge into the chosen level, a level alone is not enough
        // the arm cycles keep a stale level of the previous pin out of this test
        start_edge = (sel_level == r.pol) && (sel_prev != r.pol);

        case (r.state)
            ppm_pkg::PPM_IDLE: begin
            end
            ppm_pkg::PPM_M_ARM: begin
                next_r.dir = clear_pin(next_r.dir, r.pin_sel);
                // let the level history refill for the new pin
                if (r.cnt == ppm_pkg::ARM_CYCLES - 16'h0001) begin
                    next_r.state = ppm_pkg::PPM_M_WAIT;
                    next_r.cnt = 16'h0000;
                    next_r.wait_cnt = 16'h0000;
                    tick_clr = 1'b1;
                end else begin
                    next_r.cnt = step16(r.cnt);
                end
            end
            ppm_pkg::PPM_M_WAIT: begin
                if (start_edge) begin
                    // stopwatch starts on entry into the level
                    next_r.state = ppm_pkg::PPM_M_COUNT;
                    next_r.cnt = 16'h0000;
                    tick_clr = 1'b1;
                end else if (tick) begin
                    // give up after the wait limit with zero
                    // the limit is counted in ticks, so it follows the tick length
                    if (r.wait_cnt == WAIT_LIMIT - 16'h0001) begin
                        next_r.result = 16'h0000;
                        next_r.state = ppm_pkg::PPM_IDLE;
                    end else begin
                        next_r.wait_cnt = step16(r.wait_cnt);
                    end
                end
            end
            ppm_pkg::PPM_M_COUNT: begin
                // only whole ticks count; a partial last tick is dropped
                if (sel_level != r.pol) begin
                    // stop at the next change; width in ticks
                    next_r.result = store_width(r.cnt, r.dest8);
                    next_r.state = ppm_pkg::PPM_IDLE;
                end else if (tick) begin
                    // overflow of the 16-bit counter returns zero
                    if (r.cnt == 16'hFFFF) begin
                        next_r.result = 16'h0000;
                        next_r.state = ppm_pkg::PPM_IDLE;
                    end else begin
                        next_r.cnt = step16(r.cnt);
                    end
                end
            end
            ppm_pkg::PPM_P_DRIVE: begin
                // driver on and latch inverted on the same edge; the held latch value is not driven first
                // driver and first inversion share one edge; the pulse is timed from it
                next_r.dir = set_pin(next_r.dir, r.pin_sel);
                next_r.state = ppm_pkg::PPM_P_HOLD;
                next_r.outl = flip_pin(next_r.outl, r.pin_sel);
                next_r.cnt = 16'h0000;
                tick_clr = 1'b1;
            end
            ppm_pkg::PPM_P_HOLD: begin
                // keep the pin an output throughout
                next_r.dir = set_pin(next_r.dir, r.pin_sel);
                // end on the tick that completes len ticks; len 0 ends at once
                pulse_end = (r.len == 16'h0000) || (tick && (step16(r.cnt) == r.len));
                if (pulse_end) begin
                    next_r.outl = flip_pin(next_r.outl, r.pin_sel);
                    next_r.state = ppm_pkg::PPM_IDLE;
                end else if (tick) begin
                    // one more tick of the pulse has passed
                    next_r.cnt = step16(r.cnt);
                end
            end
            default: begin
                next_r.state = ppm_pkg::PPM_IDLE;
            end
        endcase
    end

    // state register; all pins start as inputs
    always_ff @(posedge clk) begin
        if (reset) begin
            // zero fill clears the bus answer; named fields take their own values
            r <= '0;
            r.state <= ppm_pkg::PPM_IDLE;
            r.dir <= ppm_pkg::DIR_RST;
            r.outl <= ppm_pkg::OUT_RST;
            r.len <= ppm_pkg::LEN_RST;
            r.result <= ppm_pkg::RESULT_RST;
        end else begin
            r <= next_r;
        end
    end

    // pins: driver enable is the direction bit, level is the latch
    // every output is a flop field, so no decode glitch reaches a pin or the bus
    assign pin_out = r.outl;
    assign pin_oe = r.dir;
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
endmodule

// ### testbench/ppm_ext_model.sv
// far-side circuit model: pull-ups plus a source that can pull each pin
`timescale 1ns/1ps
module ppm_ext_model (
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    output logic [15:0] pin_in
);
    logic [15:0] ext_lvl = 16'hFFFF;
    // a driven pin shows its latch, a released pin shows the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    // nonblocking, so the unit never races a level change at an edge
    task automatic drive(input int p, input logic v);
        ext_lvl[p] <= v;
    endtask
endmodule

// ### testbench/ppm_properties.sv
// port-level checks of the pin pulse measure and output unit
`timescale 1ns/1ps
module ppm_properties #(
    parameter int PINS = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic done;
    logic [3:0] sel_q;
    logic pmode;
    // a transfer completes where pready is seen in the access phase
    assign done = psel && penable && pready;
    // pin of the last start; a control write while busy would fool this
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_q <= 4'h0;
            pmode <= 1'b0;
        end else if (done && pwrite && paddr == ppm_pkg::ADDR_CTRL && pwdata[1:0] != 2'h0) begin
            sel_q <= pwdata[7:4];
            pmode <= !pwdata[0];
        end
    end
    sequence s_ctrl_go;
        done && pwrite && paddr == ppm_pkg::ADDR_CTRL;
    endsequence
    sequence s_meas_go;
        s_ctrl_go ##0 pwdata[0];
    endsequence
    sequence s_pulse_go;
        s_ctrl_go ##0 pwdata[1:0] == 2'h2;
    endsequence
    a_reset_all_inputs: assert property ($fell(reset) |-> !(|pin_oe))
        else $error("pin driven after reset");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_second_access: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_error_unmapped: assert property (pready |-> pslverr == !(paddr[1:0] == 2'h0
        && paddr <= ppm_pkg::ADDR_RESULT))
        else $error("pslverr wrong");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:17] == 15'h0000)
        else $error("upper read bits set");
    a_out_write_drives: assert property (done && pwrite && paddr == ppm_pkg::ADDR_OUT
        |=> $countones(pin_out ^ $past(pwdata[PINS-1:0])) <= 1)
        else $error("latch write not driven");
    a_dir_write_drives: assert property (done && pwrite && paddr == ppm_pkg::ADDR_DIR
        |=> $countones(pin_oe ^ $past(pwdata[PINS-1:0])) <= 1)
        else $error("direction write not applied");
    a_meas_makes_input: assert property (s_meas_go |-> ##[1:2] (!pin_oe[sel_q]) [*3])
        else $error("measured pin still output");
    a_pulse_output_first: assert property (s_pulse_go |-> ##[1:2] pin_oe[sel_q]
        ##[0:2] $changed(pin_out[sel_q]))
        else $error("pulse did not start on output");
    a_pulse_stays_output: assert property (pmode && $stable(sel_q) && $past(pin_oe[sel_q])
        && !$past(done && pwrite && paddr == ppm_pkg::ADDR_DIR) |-> pin_oe[sel_q])
        else $error("pulse pin left output");
endmodule

bind ppm_top ppm_properties #(.PINS(PINS)) u_props (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
);

// ### testbench/pin_pulse_measure_and_output_tb.sv
// self-checking bench for the pin pulse measure and output unit
`timescale 1ns/1ps
module pin_pulse_measure_and_output_tb;
    localparam int TC = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [15:0] pin_in, pin_out, pin_oe;
    int n_errors = 0;
    int tests_run = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    // short tick and start-wait limit keep the run brief
    ppm_top #(.WAIT_LIMIT(16'h0014), .TICK_CYCLES(TC)) DUT (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
    );
    ppm_ext_model ext (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // setup then access, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && t < 16) begin
            t++;
            @(posedge clk);
        end
        if (pready !== 1'b1) begin
            n_errors++;
            $display("BAD %0t no bus answer", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask
    // rest level r, a swing away from pol, then an n-cycle pulse at pol
    task automatic meas(input logic [3:0] p, input logic pol, input logic bd, input logic r,
                        input int n, input logic [15:0] exp);
        int t;
        t = 0;
        ext.drive(p, r);
        wr(ppm_pkg::ADDR_CTRL, {22'h000000, bd, pol, p, 4'h1});
        if (n > 0) begin
            repeat (6) @(posedge clk);
            ext.drive(p, ~pol);
            repeat (10) @(posedge clk);
            ext.drive(p, pol);
            repeat (n) @(posedge clk);
            ext.drive(p, ~pol);
        end
        rd = 32'h00010000;
        while (rd[16] !== 1'b0 && t < 400) begin
            t++;
            apb(1'b0, ppm_pkg::ADDR_RESULT, 32'h00000000);
        end
        check(rd, {16'h0000, exp});
        check(pin_oe[p], 1'b0);
    endtask
    // counts the cycles the latch sits inverted during a pulse
    task automatic pulse(input logic [3:0] p, input logic lat, input logic [15:0] len);
        int c;
        c = 0;
        wr(ppm_pkg::ADDR_OUT, 32'(lat) << p);
        wr(ppm_pkg::ADDR_LEN, {16'h0000, len});
        wr(ppm_pkg::ADDR_CTRL, {24'h000000, p, 4'h2});
        repeat (TC * len + 12) begin
            @(posedge clk);
            if (pin_out[p] !== lat) c++;
        end
        check(c == len * TC || c == len * TC + 1, 1'b1);
        check(pin_oe[p], 1'b1);
        check(pin_out[p], lat);
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        check(pin_oe, 16'h0000);
        rchk(ppm_pkg::ADDR_DIR, 32'h00000000);
        rchk(ppm_pkg::ADDR_OUT, 32'h00000000);
        rchk(ppm_pkg::ADDR_RESULT, 32'h00000000);
        rchk(12'h018, 32'h00000000);
        check(err, 1'b1);
        wr(ppm_pkg::ADDR_OUT, 32'h00000001);
        rchk(ppm_pkg::ADDR_IN, 32'h0000FFFF);
        rchk(ppm_pkg::ADDR_OUT, 32'h00000001);
        wr(ppm_pkg::ADDR_OUT, 32'h00000000);
        wr(ppm_pkg::ADDR_DIR, 32'h00000001);
        rchk(ppm_pkg::ADDR_IN, 32'h0000FFFE);
        wr(ppm_pkg::ADDR_OUT, 32'h00000001);
        rchk(ppm_pkg::ADDR_IN, 32'h0000FFFF);
        wr(ppm_pkg::ADDR_DIR, 32'h00000000);
        pulse(4'h5, 1'b0, 16'h0003);
        pulse(4'h5, 1'b1, 16'h0002);
        pulse(4'h7, 1'b0, 16'h0000);
        // latches match each pin's rest level so release makes no edge
        wr(ppm_pkg::ADDR_OUT, 32'h00001200);
        wr(ppm_pkg::ADDR_DIR, 32'h0000FFFF);
        meas(4'h3, 1'b1, 1'b0, 1'b0, 42, 16'h000A);
        meas(4'hC, 1'b0, 1'b0, 1'b1, 30, 16'h0007);
        meas(4'h6, 1'b1, 1'b1, 1'b0, 1042, 16'h0004);
        meas(4'h9, 1'b1, 1'b0, 1'b1, 22, 16'h0005);
        meas(4'h2, 1'b0, 1'b0, 1'b0, 0, 16'h0000);
        wrap_up();
    end
    // watchdog far beyond the roughly 1500 cycles the tests need
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule
